// ### verilog/port_framing_pkg.sv
// port framing control package: offsets, field positions, reset values, carriers
// assumes an 8-bit register port with one-cycle strobes and read data one cycle later
package port_framing_pkg;

    // register offsets for port 1; port 2 sits one stride higher
    localparam logic [7:0] off_rx_framing_control = 8'h00_A5;
    localparam logic [7:0] off_rx_filter_control = 8'h00_A6;
    localparam logic [7:0] off_rx_status = 8'h00_A7;
    localparam logic [7:0] off_rx_frame_status = 8'h00_A8;
    localparam logic [7:0] off_tx_framing_config = 8'h00_A9;
    localparam logic [7:0] off_tx_status = 8'h00_AA;
    localparam logic [7:0] off_b1_error_bitmask = 8'h00_AC;
    localparam logic [7:0] off_rx_sync_control = 8'h00_AE;
    localparam logic [7:0] off_rx_rate_select = 8'h00_A0;
    localparam logic [7:0] port_stride = 8'h00_20;

    // rx_framing_control fields
    localparam int rfc_parity_count_enable = 6;
    localparam int rfc_halt_capture_on_overflow = 5;
    localparam int rfc_descramble_bypass = 4;
    localparam int rfc_buffer_select_lo = 2;
    localparam int rfc_frame_gate = 1;
    localparam int rfc_framer_relock = 0;
    localparam logic [7:0] rfc_write_mask = 8'h00_7F;

    // rx_filter_control fields
    localparam int rflt_overhead_only = 0;
    localparam logic [7:0] rflt_write_mask = 8'h00_01;

    // rx_frame_status fields
    localparam int rfs_locked = 7;
    localparam int rfs_found = 6;
    localparam int rfs_mismatch_lo = 4;
    localparam int rfs_hit_lo = 2;
    localparam int rfs_byte_sync = 1;
    localparam int rfs_bit_sync = 0;

    // tx_framing_config fields
    localparam int tfc_format_lo = 6;
    localparam int tfc_sync_trigger = 5;
    localparam int tfc_tx_whitening_on = 3;
    localparam int tfc_local_framing = 2;
    localparam int tfc_test_data = 1;
    localparam int tfc_au_pointer_reinit = 0;
    localparam logic [7:0] tfc_write_mask = 8'h00_EF;

    // rx_sync_control fields
    localparam int rsc_arm = 7;
    localparam int rsc_ddr_to_tx = 5;
    localparam int rsc_no_frame_align = 2;
    localparam int rsc_source_lo = 0;
    localparam logic [7:0] rsc_write_mask = 8'h00_A7;

    // reset values of writable registers
    localparam logic [7:0] rst_rx_framing_control = 8'h00_00;
    localparam logic [7:0] rst_rx_filter_control = 8'h00_00;
    localparam logic [7:0] rst_tx_framing_config = 8'h00_00;
    localparam logic [7:0] rst_rx_sync_control = 8'h00_00;
    localparam logic [1:0] rst_rx_rate_select = 2'h0;

    // encodings
    localparam logic [1:0] buf_bypass = 2'h0;
    localparam logic [1:0] buf_onboard = 2'h1;
    localparam logic [1:0] fmt_otu1 = 2'h3;
    localparam logic [1:0] fmt_stm = 2'h1;
    localparam logic [1:0] src_port1 = 2'h0;

    // line rate held in the rate select field
    typedef enum logic [1:0] {
        rate_oc48 = 2'h0,
        rate_gige = 2'h1,
        rate_oc12 = 2'h2,
        rate_oc3 = 2'h3
    } line_rate_e;

    // frame format the transmit framer runs
    typedef enum logic [2:0] {
        fmt_none,
        fmt_is_otu1,
        fmt_is_stm1,
        fmt_is_stm4,
        fmt_is_stm16
    } frame_format_e;

    // framer status from the receive framer and transmit frame detector of one port
    typedef struct packed {
        logic in_frame;
        logic pattern_found;
        logic byte_sync;
        logic bit_sync;
        logic [1:0] mismatch_tally;
        logic [1:0] hit_tally;
        logic parity_error;
        logic [7:0] b1_mask;
        logic fifo_overflow;
        logic tx_frame_seen;
        logic tx_reserved_hi;
    } rx_framer_s;

    // control outputs towards one port's datapath
    typedef struct packed {
        logic capture_enable;
        logic descramble_on;
        logic [1:0] receive_buffer_select;
        logic overhead_only;
        logic framer_relock;
        logic au_pointer_reinit;
        logic tx_whitening_active;
        logic local_framing;
        logic test_data;
        logic sync_trigger_start;
        logic rx_trigger_armed;
        logic tx_trigger_armed;
        logic ddr_to_tx;
        logic no_frame_align;
        logic [1:0] trigger_source;
        frame_format_e tx_format;
        logic [15:0] parity_error_count;
    } port_ctrl_s;

endpackage

// ### verilog/framing_port_regs.sv
// framing_port_regs: register set and control decode of one line port
// assumes decoded one-cycle strobes and an 8-bit local offset within the port
`timescale 1ns/1ps
module framing_port_regs
    import port_framing_pkg::*;
#(
    parameter int count_width = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] offset,
    input wire logic [7:0] wdata,
    input wire logic [1:0] rate_select,
    input wire rx_framer_s framer,
    output logic hit,
    output logic [7:0] rdata,
    output port_ctrl_s ctrl
);

    // all state of one port except its rate select, which the top level holds
    typedef struct packed {
        logic [7:0] rx_framing_control;
        logic [7:0] rx_filter_control;
        logic [7:0] tx_framing_config;
        logic [7:0] rx_sync_control;
        logic [7:0] b1_error_bitmask;
        logic [count_width-1:0] parity_count;
        logic capture_halted;
        logic relock_prev;
        logic ptr_prev;
        logic trig_prev;
        logic relock_pulse;
        logic ptr_pulse;
        logic trig_pulse;
        logic [7:0] rdata;
    } port_state_s;

    port_state_s cur;
    port_state_s next_cur;
    logic [7:0] read_mux; // combinational read selection

    // address match for any mapped register
    always_comb begin
        unique case (offset)
            off_rx_framing_control, off_rx_filter_control, off_rx_status,
            off_rx_frame_status, off_tx_framing_config, off_tx_status,
            off_b1_error_bitmask, off_rx_sync_control: hit = 1'b1;
            default: hit = 1'b0; // unmapped offset
        endcase
    end

    // read selection
    always_comb begin
        read_mux = 8'h00_00;
        unique case (offset)
            off_rx_framing_control: read_mux = cur.rx_framing_control;
            off_rx_filter_control: read_mux = cur.rx_filter_control;
            off_rx_status: read_mux = {7'h00, framer.in_frame};
            off_rx_frame_status: begin
                read_mux[rfs_locked] = framer.in_frame;
                read_mux[rfs_found] = framer.pattern_found;
                read_mux[rfs_mismatch_lo +: 2] = framer.mismatch_tally;
                read_mux[rfs_hit_lo +: 2] = framer.hit_tally;
                read_mux[rfs_byte_sync] = framer.byte_sync;
                read_mux[rfs_bit_sync] = framer.bit_sync;
            end
            off_tx_framing_config: read_mux = cur.tx_framing_config;
            // upper bits reserved; bit 7 carries an uncommitted framer bit, bits 6 to 1 read zero
            off_tx_status: read_mux = {framer.tx_reserved_hi, 6'h00,
                framer.tx_frame_seen};
            off_b1_error_bitmask: read_mux = cur.b1_error_bitmask;
            off_rx_sync_control: read_mux = cur.rx_sync_control;
            default: read_mux = 8'h00_00;
        endcase
    end

    // next-state logic
    always_comb begin
        next_cur = cur;
        // writes, reserved bits masked off
        if (wr_en) begin
            unique case (offset)
                off_rx_framing_control:
                    next_cur.rx_framing_control = wdata & rfc_write_mask;
                off_rx_filter_control:
                    next_cur.rx_filter_control = wdata & rflt_write_mask;
                off_tx_framing_config:
                    next_cur.tx_framing_config = wdata & tfc_write_mask;
                off_rx_sync_control: next_cur.rx_sync_control = wdata & rsc_write_mask;
                default: ;
            endcase
        end
        // parity counter runs while enabled, cleared when the enable is low
        if (!cur.rx_framing_control[rfc_parity_count_enable]) begin
            next_cur.parity_count = '0;
        end else if (framer.parity_error && cur.parity_count != '1) begin
            next_cur.parity_count = cur.parity_count + 1'b1;
        end
        // latest b1 mask kept on each parity error
        if (framer.parity_error) begin
            next_cur.b1_error_bitmask = framer.b1_mask;
        end
        // overflow halts capture while the halt option is on; clearing it resumes
        if (!cur.rx_framing_control[rfc_halt_capture_on_overflow]) begin
            next_cur.capture_halted = 1'b0;
        end else if (framer.fifo_overflow) begin
            next_cur.capture_halted = 1'b1;
        end
        // falling edges of the relock and pointer bits, and the rising edge of the sync trigger bit, become one-cycle commands
        next_cur.relock_prev = cur.rx_framing_control[rfc_framer_relock];
        next_cur.ptr_prev = cur.tx_framing_config[tfc_au_pointer_reinit];
        next_cur.trig_prev = cur.tx_framing_config[tfc_sync_trigger];
        next_cur.relock_pulse = cur.relock_prev
            & ~cur.rx_framing_control[rfc_framer_relock];
        next_cur.ptr_pulse = cur.ptr_prev & ~cur.tx_framing_config[tfc_au_pointer_reinit];
        next_cur.trig_pulse = ~cur.trig_prev & cur.tx_framing_config[tfc_sync_trigger];
        // read data stand one cycle only; a stale copy would leak into the shared or
        next_cur.rdata = rd_en ? read_mux : 8'h00_00;
    end

    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur <= '0;
            cur.rx_framing_control <= rst_rx_framing_control;
            cur.rx_filter_control <= rst_rx_filter_control;
            cur.tx_framing_config <= rst_tx_framing_config;
            cur.rx_sync_control <= rst_rx_sync_control;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata = cur.rdata;

    // control decode towards the datapath
    always_comb begin
        logic gate;
        logic [1:0] fmt;
        gate = cur.rx_framing_control[rfc_frame_gate];
        fmt = cur.tx_framing_config[tfc_format_lo +: 2];
        ctrl = '0;
        // capture only while locked when gated, never while halted
        ctrl.capture_enable = (~gate | framer.in_frame) & ~cur.capture_halted;
        // bypass only counts once gated and in frame
        ctrl.descramble_on = gate & framer.in_frame
            & ~cur.rx_framing_control[rfc_descramble_bypass];
        ctrl.receive_buffer_select = cur.rx_framing_control[rfc_buffer_select_lo +: 2];
        ctrl.overhead_only = cur.rx_filter_control[rflt_overhead_only];
        ctrl.framer_relock = cur.relock_pulse;
        ctrl.au_pointer_reinit = cur.ptr_pulse;
        ctrl.sync_trigger_start = cur.trig_pulse;
        ctrl.tx_whitening_active = cur.tx_framing_config[tfc_tx_whitening_on]
            & framer.tx_frame_seen;
        ctrl.local_framing = cur.tx_framing_config[tfc_local_framing];
        ctrl.test_data = cur.tx_framing_config[tfc_test_data];
        ctrl.rx_trigger_armed = cur.rx_sync_control[rsc_arm];
        ctrl.tx_trigger_armed = cur.rx_sync_control[rsc_arm];
        ctrl.trigger_source = cur.rx_sync_control[rsc_source_lo +: 2];
        ctrl.ddr_to_tx = cur.rx_sync_control[rsc_ddr_to_tx];
        ctrl.no_frame_align = cur.rx_sync_control[rsc_no_frame_align];
        // format from the two format bits and the line rate
        ctrl.tx_format = fmt_none;
        if (fmt == fmt_otu1 && rate_select == 2'(rate_oc48)) begin
            ctrl.tx_format = fmt_is_otu1;
        end else if (fmt == fmt_stm) begin
            unique case (line_rate_e'(rate_select))
                rate_oc48: ctrl.tx_format = fmt_is_stm16;
                rate_oc12: ctrl.tx_format = fmt_is_stm4;
                rate_oc3: ctrl.tx_format = fmt_is_stm1;
                rate_gige: ctrl.tx_format = fmt_none; // no sdh frame at gigabit rate
            endcase
        end
        ctrl.parity_error_count = 16'(cur.parity_count);
    end

endmodule // framing_port_regs

// ### verilog/sonet_port_framing_control.sv
// sonet_port_framing_control: framing registers of two line ports
// assumes one 100 MHz clock, synchronous reset, register port with one-cycle strobes
`timescale 1ns/1ps
module sonet_port_framing_control
    import port_framing_pkg::*;
#(
    parameter int count_width = 16, // parity counter width
    parameter int num_ports = 2 // port count
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire rx_framer_s [num_ports-1:0] framer,
    output port_ctrl_s [num_ports-1:0] ctrl
);

    // top-level state: the rate select of each port and the read strobe copy
    typedef struct packed {
        logic [num_ports-1:0][1:0] rate_select;
        logic read_pending;
    } top_state_s;

    top_state_s cur;
    top_state_s next_cur;
    logic [num_ports-1:0] port_hit; // per-port offset match
    logic [num_ports-1:0][7:0] port_rdata; // per-port read data
    logic [num_ports-1:0][7:0] local_off; // offset relative to port 1 map

    // one register set per port at a fixed stride
    for (genvar p = 0; p < num_ports; p++) begin : g_port
        logic sel;
        assign local_off[p] = addr - 8'(p * port_stride);
        assign sel = port_hit[p];
        framing_port_regs #(
            .count_width(count_width)
        ) u_regs (
            .mclk(mclk),
            .reset(reset),
            .wr_en(wr_en & sel),
            .rd_en(rd_en & sel),
            .offset(local_off[p]),
            .wdata(wdata),
            .rate_select(cur.rate_select[p]),
            .framer(framer[p]),
            .hit(port_hit[p]),
            .rdata(port_rdata[p]),
            .ctrl(ctrl[p])
        );
    end

    // rate select register of each port, low bits of the rate field
    always_comb begin
        next_cur = cur;
        next_cur.read_pending = rd_en;
        for (int p = 0; p < num_ports; p++) begin
            if (wr_en && local_off[p] == off_rx_rate_select) begin
                next_cur.rate_select[p] = wdata[3:2];
            end
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // read data: the addressed port, or zero when unmapped; rate select does not read back
    always_comb begin
        rdata = 8'h00_00;
        if (cur.read_pending) begin
            for (int p = 0; p < num_ports; p++) begin
                rdata = rdata | port_rdata[p];
            end
        end
    end

endmodule // sonet_port_framing_control

// ### sim/framing_regs_assertions.sv
// checker for the framing register block, watching port 1 controls
// assumes it is bound into sonet_port_framing_control and sees only its ports
`timescale 1ns/1ps
module framing_regs_assertions
    import port_framing_pkg::*;
#(
    parameter int count_width = 16,
    parameter int num_ports = 2
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire rx_framer_s [num_ports-1:0] framer,
    input wire port_ctrl_s [num_ports-1:0] ctrl
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    logic [7:0] rfc; // shadow of port 1 receive framing control
    logic [7:0] tfc; // shadow of port 1 transmit framing config
    logic [7:0] rsc; // shadow of port 1 receive sync control
    // shadows track writes so control levels are known without peeking inside
    always_ff @(posedge mclk) begin
        if (reset) begin
            rfc <= 8'h00;
            tfc <= 8'h00;
            rsc <= 8'h00;
        end else if (wr_en && addr == off_rx_framing_control) begin
            rfc <= wdata & rfc_write_mask;
        end else if (wr_en && addr == off_tx_framing_config) begin
            tfc <= wdata & tfc_write_mask;
        end else if (wr_en && addr == off_rx_sync_control) begin
            rsc <= wdata & rsc_write_mask;
        end
    end
    idle_read_a: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    framed_read_a: assert property (rd_en && addr == off_rx_status |=>
        rdata == {7'h00, $past(framer[0].in_frame)})
        else $error("receive status read wrong");
    lock_mirror_a: assert property (rd_en && addr == off_rx_frame_status |=>
        rdata[7] == $past(framer[0].in_frame))
        else $error("lock bit does not mirror framed");
    sync_flags_a: assert property (rd_en && addr == off_rx_frame_status |=>
        rdata[1:0] == {$past(framer[0].byte_sync), $past(framer[0].bit_sync)})
        else $error("sync flags read wrong");
    tally_read_a: assert property (rd_en && addr == off_rx_frame_status |=>
        rdata[5:2] == {$past(framer[0].mismatch_tally), $past(framer[0].hit_tally)})
        else $error("tallies read wrong");
    gate_lock_a: assert property (rfc[1] && !framer[0].in_frame |->
        !ctrl[0].capture_enable)
        else $error("capture open while unlocked");
    bypass_only_a: assert property (rfc[1] && framer[0].in_frame |->
        ctrl[0].descramble_on == !rfc[4])
        else $error("descramble level wrong");
    relock_pulse_a: assert property ($fell(rfc[0]) |-> ##[0:2] ctrl[0].framer_relock)
        else $error("no relock pulse");
    ptr_pulse_a: assert property ($fell(tfc[0]) |-> ##[0:2] ctrl[0].au_pointer_reinit)
        else $error("no pointer reset pulse");
    trig_single_a: assert property (ctrl[0].sync_trigger_start |=>
        !ctrl[0].sync_trigger_start)
        else $error("trigger pulse too long");
    whiten_gate_a: assert property (ctrl[0].tx_whitening_active ==
        (tfc[3] && framer[0].tx_frame_seen))
        else $error("scramble not tied to frame seen");
    arm_both_a: assert property (ctrl[0].rx_trigger_armed == rsc[7]
        && ctrl[0].tx_trigger_armed == rsc[7])
        else $error("triggers armed apart");
endmodule // framing_regs_assertions

bind sonet_port_framing_control framing_regs_assertions #(
    .count_width(count_width),
    .num_ports(num_ports)
) i_framing_regs_assertions (
    .mclk(mclk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .framer(framer),
    .ctrl(ctrl)
);

// ### sim/framer_model.sv
// stand-in for one port's receive framer and transmit frame detector
// assumes the bench raises one-cycle requests for errors and overflow
`timescale 1ns/1ps
module framer_model
    import port_framing_pkg::*;
#(
    parameter int lock_delay = 8 // search time before lock returns
) (
    input wire logic mclk,
    input wire logic reset,
    input wire port_ctrl_s ctrl,
    input wire logic lock_req,
    input wire logic err_req,
    input wire logic [7:0] err_mask,
    input wire logic ovf_req,
    input wire logic tx_seen,
    output rx_framer_s framer
);
    int wait_cnt; // cycles left in the pattern search
    // all status moves on the clock; mask toggles so a stale latch shows
    always @(posedge mclk) begin
        framer.parity_error <= err_req;
        framer.b1_mask <= err_req ? err_mask : ~framer.b1_mask;
        framer.fifo_overflow <= ovf_req;
        framer.tx_frame_seen <= tx_seen;
        framer.tx_reserved_hi <= tx_seen; // reserved bit left noisy
        framer.pattern_found <= framer.in_frame;
        framer.byte_sync <= framer.in_frame;
        framer.bit_sync <= framer.in_frame;
        framer.mismatch_tally <= framer.in_frame ? 2'h1 : 2'h0;
        framer.hit_tally <= framer.in_frame ? 2'h3 : 2'h0;
        if (reset || !lock_req || ctrl.framer_relock) begin
            wait_cnt <= lock_delay; // relock drops lock, search restarts
            framer.in_frame <= 1'b0;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else begin
            framer.in_frame <= 1'b1;
        end
    end
endmodule // framer_model

// ### sim/sonet_port_framing_control_tb.sv
// self-checking bench for the two-port framing register block
// assumes framer_model stands in for each port's far side
`timescale 1ns/1ps
module sonet_port_framing_control_tb
    import port_framing_pkg::*;
();
    logic mclk, reset, wr_en, rd_en;
    logic [7:0] addr, wdata, rdata, err_mask;
    logic [1:0] lock_req, err_req, ovf_req, tx_seen; // per-port far-side steering
    rx_framer_s [1:0] framer;
    port_ctrl_s [1:0] ctrl;
    int errors, compares, relock_n, ptr_n, trig_n;
    logic [7:0] offs [4] = '{off_rx_framing_control, off_rx_filter_control,
        off_tx_framing_config, off_rx_sync_control};
    logic [7:0] masks [4] = '{rfc_write_mask, rflt_write_mask, tfc_write_mask,
        rsc_write_mask};

    sonet_port_framing_control i_sonet_port_framing_control (.mclk(mclk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .framer(framer), .ctrl(ctrl));
    for (genvar p = 0; p < 2; p++) begin : g_port
        framer_model i_framer_model (.mclk(mclk), .reset(reset), .ctrl(ctrl[p]),
            .lock_req(lock_req[p]), .err_req(err_req[p]), .err_mask(err_mask),
            .ovf_req(ovf_req[p]), .tx_seen(tx_seen[p]), .framer(framer[p]));
    end
    // clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // tally port 1 pulses so scenarios count them
    always @(posedge mclk) begin
        if (ctrl[0].framer_relock === 1'b1) relock_n++;
        if (ctrl[0].au_pointer_reinit === 1'b1) ptr_n++;
        if (ctrl[0].sync_trigger_start === 1'b1) trig_n++;
    end
    task automatic test_done();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(16'(rdata), 16'(exp), "read");
    endtask
    // one-cycle port 1 request: overflow when ovf is set, else a parity error
    task automatic pulse(input bit ovf, input logic [7:0] m);
        @(posedge mclk);
        if (ovf) ovf_req <= 2'h1;
        else err_req <= 2'h1;
        err_mask <= m;
        @(posedge mclk);
        ovf_req <= 2'h0;
        err_req <= 2'h0;
    endtask
    // bounded wait for port 1 lock; a hang ends the run
    task automatic wait_frame();
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            if (framer[0].in_frame === 1'b1) return;
        end
        errors++;
        $display("mismatch at %0t: lock never came", $time);
        test_done();
    endtask
    task automatic s_reset();
        for (int i = 0; i < 8; i++) rd(8'h00_A5 + 8'(i) + ((i > 5) ? 8'(i - 5) : 8'h00), 8'h00);
        rd(8'h00_C5, 8'h00);
        rd(8'h00_B0, 8'h00); // unmapped place reads zero
    endtask
    task automatic s_masks();
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 4; r++) begin
                wr(offs[r] + 8'(p) * port_stride, 8'h00_FF);
                rd(offs[r] + 8'(p) * port_stride, masks[r]);
                rd(offs[r] + 8'(1 - p) * port_stride, p ? masks[r] : 8'h00);
            end
            chk(16'(ctrl[p].receive_buffer_select), 16'h3, "test source");
            chk(16'(ctrl[p].overhead_only), 16'h1, "overhead");
            chk({ctrl[p].ddr_to_tx, ctrl[p].no_frame_align, ctrl[p].trigger_source},
                16'hF, "sync");
            chk({ctrl[p].rx_trigger_armed, ctrl[p].tx_trigger_armed}, 16'h3, "arm");
            chk({ctrl[p].local_framing, ctrl[p].test_data}, 16'h3, "tx mode");
        end
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 4; r++) wr(offs[r] + 8'(p) * port_stride, 8'h00);
        end
        chk({ctrl[1].local_framing, ctrl[1].test_data, ctrl[1].trigger_source},
            16'h0, "off");
        wr(off_rx_framing_control, 8'h04);
        chk(16'(ctrl[0].receive_buffer_select), 16'(buf_onboard), "onboard");
    endtask
    task automatic s_status();
        @(posedge mclk);
        lock_req <= 2'h1;
        tx_seen <= 2'h1;
        wait_frame();
        rd(off_rx_status, 8'h01);
        rd(off_rx_frame_status, 8'h00_DF);
        rd(off_tx_status, 8'h81);
        rd(off_rx_status + port_stride, 8'h00);
    endtask
    task automatic s_capture();
        wr(off_rx_framing_control, 8'h02);
        chk({ctrl[0].capture_enable, ctrl[0].descramble_on}, 16'h3, "gated");
        wr(off_rx_framing_control, 8'h12);
        chk(16'(ctrl[0].descramble_on), 16'h0, "bypass");
        wr(off_rx_framing_control + port_stride, 8'h02);
        chk(16'(ctrl[1].capture_enable), 16'h0, "unlocked");
        wr(off_rx_framing_control, 8'h20);
        pulse(1'b1, 8'h00);
        repeat (3) @(posedge mclk);
        chk(16'(ctrl[0].capture_enable), 16'h0, "halted");
        wr(off_rx_framing_control, 8'h00);
        // the halt releases one cycle after the option clears
        @(posedge mclk);
        #1;
        chk(16'(ctrl[0].capture_enable), 16'h1, "resumed");
    endtask
    task automatic s_parity();
        wr(off_rx_framing_control, 8'h40);
        pulse(1'b0, 8'h00_A5);
        pulse(1'b0, 8'h3C);
        repeat (3) @(posedge mclk);
        chk(ctrl[0].parity_error_count, 16'h2, "count");
        rd(off_b1_error_bitmask, 8'h3C);
        wr(off_rx_framing_control, 8'h00);
        // the counter clears one cycle after the enable drops
        @(posedge mclk);
        #1;
        chk(ctrl[0].parity_error_count, 16'h0, "cleared");
    endtask
    task automatic s_relock();
        int base;
        base = relock_n;
        wr(off_rx_framing_control, 8'h01);
        wr(off_rx_framing_control, 8'h00);
        repeat (4) @(posedge mclk);
        chk(16'(relock_n - base), 16'h1, "relock");
        chk(16'(framer[0].in_frame), 16'h0, "dropped");
        wait_frame();
        rd(off_rx_status, 8'h01);
    endtask
    task automatic s_tx();
        int pb, tb;
        pb = ptr_n;
        tb = trig_n;
        wr(off_tx_framing_config, 8'h21);
        wr(off_tx_framing_config, 8'h08);
        repeat (4) @(posedge mclk);
        chk(16'(ptr_n - pb), 16'h1, "pointer");
        chk(16'(trig_n - tb), 16'h1, "trigger");
        chk(16'(ctrl[0].tx_whitening_active), 16'h1, "scramble");
        tx_seen <= 2'h0;
        repeat (2) @(posedge mclk);
        chk(16'(ctrl[0].tx_whitening_active), 16'h0, "no frame");
    endtask
    task automatic s_format();
        logic [1:0] rates [5] = '{2'h0, 2'h3, 2'h2, 2'h0, 2'h1};
        logic [1:0] fmts [5] = '{2'h3, 2'h1, 2'h1, 2'h1, 2'h1};
        frame_format_e exp [5] = '{fmt_is_otu1, fmt_is_stm1, fmt_is_stm4, fmt_is_stm16,
            fmt_none};
        for (int i = 0; i < 5; i++) begin
            wr(off_rx_rate_select, {4'h0, rates[i], 2'h0});
            wr(off_tx_framing_config, {fmts[i], 6'h00});
            chk(16'(ctrl[0].tx_format), 16'(exp[i]), "format");
        end
    endtask
    // main sequence
    initial begin
        {reset, wr_en, rd_en, addr, wdata, err_mask} = {1'b1, 26'h0};
        {lock_req, err_req, ovf_req, tx_seen} = 8'h00;
        {errors, compares, relock_n, ptr_n, trig_n} = '0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        s_reset();
        s_masks();
        s_status();
        s_capture();
        s_parity();
        s_relock();
        s_tx();
        s_format();
        test_done();
    end
endmodule // sonet_port_framing_control_tb
